// [edge_wake_filter.sv]
// per-pin glitch filter and sticky edge flags for one interrupt port
// assumes sample_en is high every clock in run and wait
`timescale 1ns/1ps
`include "pin_cfg.svh"
module edge_wake_filter #(
  parameter int N = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic sample_en,
  input wire logic [N-1:0] pin,
  wake_if.filt w
);
  logic [N-1:0] busy;

  // ==========================================
  // per-pin filter
  for (genvar i = 0; i < N; i++) begin : g_pin
    logic [2:0] pas_cnt_r, act_cnt_r;
    logic armed_r, act, set;
    assign act = w.polarity[i] ? pin[i] : ~pin[i];
    assign set = sample_en & act & armed_r & (act_cnt_r == 3'(`FILT_SAMPLES - 1));
    assign busy[i] = w.enable[i] & ~w.flags[i] & (act_cnt_r <= 3'(`FILT_SAMPLES));
    always_ff @(posedge clk) begin
      if (srst) begin
        pas_cnt_r <= 3'h0;
        act_cnt_r <= 3'h0;
        armed_r <= 1'b0;
      end else if (sample_en) begin
        if (!act) begin
          act_cnt_r <= 3'h0;
          if (pas_cnt_r != 3'(`FILT_SAMPLES)) pas_cnt_r <= pas_cnt_r + 3'h1;
          if (pas_cnt_r == 3'(`FILT_SAMPLES - 1)) armed_r <= 1'b1;
        end else begin
          pas_cnt_r <= 3'h0;
          if (set) begin
            act_cnt_r <= 3'h0;
            armed_r <= 1'b0;
          end else if (armed_r) begin
            act_cnt_r <= act_cnt_r + 3'h1;
          end
        end
      end
    end
    always_ff @(posedge clk) begin
      if (srst) w.flags[i] <= 1'b0;
      else w.flags[i] <= set | (w.flags[i] & ~(w.clr_stb & w.clr_mask[i]));
    end
  end

  // ==========================================
  // shared request
  always_ff @(posedge clk) begin
    if (srst) begin
      w.irq <= 1'b0;
      w.rc_run <= 1'b0;
    end else begin
      w.irq <= |(w.flags & w.enable);
      w.rc_run <= |busy;
    end
  end

endmodule : edge_wake_filter

// [pin_cfg.svh]
// constants for the port integration pin logic
// assumes a 20 MHz ref_clk and the pin map below
`ifndef PIN_CFG_SVH
`define PIN_CFG_SVH

// ==========================================
// timing
`define CLK_NS 50
`define FILT_SAMPLES 4
`define STOP_IGNORE_NS 3200
`define STOP_VALID_NS 10000
// stop-mode sample period, longest that still accepts a valid pulse
`define RC_DIV_CYC (`STOP_VALID_NS / (`FILT_SAMPLES * `CLK_NS))

// ==========================================
// pin map: width and lsb of each port in the flat pin vectors
`define PIN_TOTAL 36
`define W_TIM 8
`define W_SER 4
`define W_BUS 6
`define W_KEY 8
`define W_AUX 2
`define W_ANA 8
`define LSB_TIM 0
`define LSB_SER 8
`define LSB_BUS 12
`define LSB_KEY 18
`define LSB_AUX 26
`define LSB_ANA 28
`define N_PORTS 6
`define W_ROUTE 4

// ==========================================
// reset values
`define PULL_RST_ON 8'hff
`define PULL_RST_OFF 8'h00
`define CFG_RST 8'h00

`endif

// [pin_partner.sv]
// model of the board around the pins: outside drivers, pulls, floating lines
// assumes the block's registered pin outputs
`timescale 1ns/1ps
`include "pin_cfg.svh"
module pin_partner (
  input wire logic clk,
  input wire logic [`PIN_TOTAL-1:0] pin_out,
  input wire logic [`PIN_TOTAL-1:0] pin_oe_n,
  input wire logic [`PIN_TOTAL-1:0] pull_on,
  input wire logic [`PIN_TOTAL-1:0] pull_up,
  input wire logic [`PIN_TOTAL-1:0] ext_en,
  input wire logic [`PIN_TOTAL-1:0] ext_val,
  output logic [`PIN_TOTAL-1:0] pin_lvl
);
  // floating lines change every cycle
  logic tog_r = 1'b0;
  always_ff @(posedge clk) begin
    tog_r <= ~tog_r;
  end
  always_comb begin
    for (int i = 0; i < `PIN_TOTAL; i++) begin
      pin_lvl[i] = ext_en[i] ? ext_val[i] : !pin_oe_n[i] ? pin_out[i] : pull_on[i] ? pull_up[i] : tog_r ^ i[0];
    end
  end
endmodule : pin_partner

// [pin_pkg.sv]
// types shared by the port integration pin logic
// assumes nothing beyond the header constants
package pin_pkg;

  typedef enum logic [2:0] {
    PORT_TIM = 3'h0,
    PORT_SER = 3'h1,
    PORT_BUS = 3'h2,
    PORT_KEY = 3'h3,
    PORT_AUX = 3'h4,
    PORT_ANA = 3'h5
  } port_sel_t;

  typedef enum logic [2:0] {
    REG_DATA = 3'h0,
    REG_DIR = 3'h1,
    REG_RDRV = 3'h2,
    REG_PULLEN = 3'h3,
    REG_PULLSEL = 3'h4,
    REG_WOR = 3'h5,
    REG_IE = 3'h6,
    REG_AUX = 3'h7
  } reg_sel_t;

endpackage : pin_pkg

// [pin_port_slice.sv]
// one port: configuration registers and pin multiplexing
// assumes pin_in and peripheral signals synchronous to clk
`timescale 1ns/1ps
`include "pin_cfg.svh"
module pin_port_slice #(
  parameter int WIDTH = 8,
  parameter logic [7:0] PULL_RST = `PULL_RST_OFF
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire pin_pkg::reg_sel_t wr_sel,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] periph_en,
  input wire logic [WIDTH-1:0] periph_out,
  input wire logic [WIDTH-1:0] periph_oe,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe_n,
  output logic [WIDTH-1:0] rdrv,
  output logic [WIDTH-1:0] pull_on,
  output logic [WIDTH-1:0] pull_up,
  output logic [WIDTH-1:0] data_rd,
  output logic [WIDTH-1:0] pin_rd,
  output logic [WIDTH-1:0] pol
);
  logic [WIDTH-1:0] data_r, dir_r, rdrv_r, pullen_r, wor_r;
  logic [WIDTH-1:0] out_mode, out_val;

  // ==========================================
  // configuration registers
  always_ff @(posedge clk) begin
    if (srst) begin
      data_r <= WIDTH'(`CFG_RST);
      dir_r <= '0;
      rdrv_r <= '0;
      pullen_r <= PULL_RST[WIDTH-1:0];
      pol <= PULL_RST[WIDTH-1:0];
      wor_r <= '0;
    end else if (wr_en) begin
      case (wr_sel)
        pin_pkg::REG_DATA: data_r <= wdata;
        pin_pkg::REG_DIR: dir_r <= wdata;
        pin_pkg::REG_RDRV: rdrv_r <= wdata;
        pin_pkg::REG_PULLEN: pullen_r <= wdata;
        pin_pkg::REG_PULLSEL: pol <= wdata;
        pin_pkg::REG_WOR: wor_r <= wdata;
        default: ;
      endcase
    end
  end

  // ==========================================
  // pin multiplexing
  assign out_mode = (periph_en & periph_oe) | (~periph_en & dir_r);
  assign out_val = (periph_en & periph_out) | (~periph_en & data_r);

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_out <= '0;
      pin_oe_n <= '1;
      rdrv <= '0;
      pull_on <= PULL_RST[WIDTH-1:0];
      pull_up <= PULL_RST[WIDTH-1:0];
      data_rd <= '0;
      pin_rd <= '0;
    end else begin
      pin_out <= out_val;
      pin_oe_n <= ~(out_mode & (~wor_r | ~out_val));
      rdrv <= rdrv_r & out_mode;
      pull_on <= pullen_r & (~out_mode | wor_r);
      pull_up <= out_mode | pol;
      data_rd <= (dir_r & data_r) | (~dir_r & pin_in);
      pin_rd <= pin_in;
    end
  end

endmodule : pin_port_slice

// [port_integration_pin_logic.sv]
// top of the port integration pin logic: six ports, routing, two wake ports
// assumes synchronous pins, a 20 MHz ref_clk and a plain configuration write port
`timescale 1ns/1ps
`include "pin_cfg.svh"

// Summary of operation
// - data read gives pin when input, latch when output
// - data writes always stored, driven only as output
// - input read always returns pin level
// - direction ignored when peripheral owns pin
// - reduced drive only matters for outputs
// - pull active for input or wired-or output
// - pull select chooses up/down; wired-or only up
// - keywake port has eight edge interrupts, one request
// - request while any flag and enable set
// - interrupt wakes from stop and wait
// - bus clock filter ignores 3, accepts 4
// - edge needs 4 passive then 4 active samples
// - stop filter ignores 3.2us, accepts 10us
// - filter on bus clock, RC clock in stop
// - RC clock runs only in stop while some enabled pin has no flag set
// - aux port of two pins behaves alike
// - wake paths kept in stop
// - timer, keywake, aux ports reset as hi-z inputs
// - serial ports reset as pulled-up inputs
// - reduced drive and interrupt enables reset off
// - every register cleared or set by reset
// - timer pins take rerouted pulse outputs per routing
// - flag cleared only by writing one
// - edge direction follows polarity select
// - direction change reaches reads within two cycles
module port_integration_pin_logic #(
  parameter int RC_DIV = `RC_DIV_CYC
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic cfg_wr_en,
  input wire pin_pkg::port_sel_t cfg_port,
  input wire pin_pkg::reg_sel_t cfg_reg,
  input wire logic [7:0] cfg_wdata,
  input wire logic [`PIN_TOTAL-1:0] pin_in,
  input wire logic [`PIN_TOTAL-1:0] periph_en,
  input wire logic [`PIN_TOTAL-1:0] periph_out,
  input wire logic [`PIN_TOTAL-1:0] periph_oe,
  input wire logic [`W_ROUTE-1:0] pwm_reroute_out,
  input wire logic stop_mode,
  output logic [`PIN_TOTAL-1:0] pin_out,
  output logic [`PIN_TOTAL-1:0] pin_oe_n,
  output logic [`PIN_TOTAL-1:0] pin_rdrv,
  output logic [`PIN_TOTAL-1:0] pin_pull_on,
  output logic [`PIN_TOTAL-1:0] pin_pull_up,
  output logic [`PIN_TOTAL-1:0] data_rd,
  output logic [`PIN_TOTAL-1:0] pin_rd,
  output logic [`W_ROUTE-1:0] module_routing_select,
  output logic [`W_KEY-1:0] keywake_interrupt_enables,
  output logic [`W_AUX-1:0] aux_interrupt_enables,
  output logic [`W_KEY-1:0] keywake_interrupt_flags,
  output logic [`W_AUX-1:0] aux_interrupt_flags,
  output logic keywake_irq,
  output logic aux_irq,
  output logic stop_wake,
  output logic rc_osc_run
);

  // ==========================================
  // port geometry
  function automatic int port_w(input int p);
    case (p)
      0: port_w = `W_TIM;
      1: port_w = `W_SER;
      2: port_w = `W_BUS;
      3: port_w = `W_KEY;
      4: port_w = `W_AUX;
      default: port_w = `W_ANA;
    endcase
  endfunction : port_w

  function automatic int port_lsb(input int p);
    case (p)
      0: port_lsb = `LSB_TIM;
      1: port_lsb = `LSB_SER;
      2: port_lsb = `LSB_BUS;
      3: port_lsb = `LSB_KEY;
      4: port_lsb = `LSB_AUX;
      default: port_lsb = `LSB_ANA;
    endcase
  endfunction : port_lsb

  // ==========================================
  // declarations
  logic [`PIN_TOTAL-1:0] pe, po, poe, pol_all;
  logic [`W_ROUTE-1:0] route_r;
  logic [`W_KEY-1:0] ie_key_r;
  logic [`W_AUX-1:0] ie_aux_r;
  logic [6:0] rc_cnt_r;
  logic rc_tick_r;
  logic sample_en;
  logic ie_wr, route_wr;

  wake_if #(.N(`W_KEY)) wk ();
  wake_if #(.N(`W_AUX)) wa ();

  // ==========================================
  // timer routing
  assign route_wr = cfg_wr_en & (cfg_port == pin_pkg::PORT_TIM) & (cfg_reg == pin_pkg::REG_AUX);

  always_ff @(posedge ref_clk) begin
    if (srst) route_r <= `W_ROUTE'(0);
    else if (route_wr) route_r <= cfg_wdata[`W_ROUTE-1:0];
  end

  always_ff @(posedge ref_clk) begin
    if (srst) module_routing_select <= `W_ROUTE'(0);
    else module_routing_select <= route_r;
  end

  always_comb begin
    pe = periph_en;
    po = periph_out;
    poe = periph_oe;
    for (int i = 0; i < `W_ROUTE; i++) begin
      if (route_r[i]) begin
        pe[`LSB_TIM + i] = 1'b1;
        po[`LSB_TIM + i] = pwm_reroute_out[i];
        poe[`LSB_TIM + i] = 1'b1;
      end
    end
  end

  // ==========================================
  // port slices
  for (genvar g = 0; g < `N_PORTS; g++) begin : g_port
    localparam int W = port_w(g);
    localparam int L = port_lsb(g);
    localparam logic [7:0] PR = (g == 1 || g == 2) ? `PULL_RST_ON : `PULL_RST_OFF;
    logic wr;
    assign wr = cfg_wr_en & (cfg_port == pin_pkg::port_sel_t'(g));
    pin_port_slice #(
      .WIDTH(W),
      .PULL_RST(PR)
    ) u_slice (
      .clk(ref_clk),
      .srst(srst),
      .wr_en(wr),
      .wr_sel(cfg_reg),
      .wdata(cfg_wdata[W-1:0]),
      .pin_in(pin_in[L +: W]),
      .periph_en(pe[L +: W]),
      .periph_out(po[L +: W]),
      .periph_oe(poe[L +: W]),
      .pin_out(pin_out[L +: W]),
      .pin_oe_n(pin_oe_n[L +: W]),
      .rdrv(pin_rdrv[L +: W]),
      .pull_on(pin_pull_on[L +: W]),
      .pull_up(pin_pull_up[L +: W]),
      .data_rd(data_rd[L +: W]),
      .pin_rd(pin_rd[L +: W]),
      .pol(pol_all[L +: W])
    );
  end

  // ==========================================
  // interrupt enables and flag clears
  assign ie_wr = cfg_wr_en & (cfg_reg == pin_pkg::REG_IE);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ie_key_r <= `W_KEY'(0);
      ie_aux_r <= `W_AUX'(0);
    end else if (ie_wr) begin
      if (cfg_port == pin_pkg::PORT_KEY) ie_key_r <= cfg_wdata[`W_KEY-1:0];
      if (cfg_port == pin_pkg::PORT_AUX) ie_aux_r <= cfg_wdata[`W_AUX-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      keywake_interrupt_enables <= `W_KEY'(0);
      aux_interrupt_enables <= `W_AUX'(0);
    end else begin
      keywake_interrupt_enables <= ie_key_r;
      aux_interrupt_enables <= ie_aux_r;
    end
  end

  assign wk.enable = ie_key_r;
  assign wk.polarity = pol_all[`LSB_KEY +: `W_KEY];
  assign wk.clr_mask = cfg_wdata[`W_KEY-1:0];
  assign wk.clr_stb = cfg_wr_en & (cfg_port == pin_pkg::PORT_KEY) & (cfg_reg == pin_pkg::REG_AUX);

  assign wa.enable = ie_aux_r;
  assign wa.polarity = pol_all[`LSB_AUX +: `W_AUX];
  assign wa.clr_mask = cfg_wdata[`W_AUX-1:0];
  assign wa.clr_stb = cfg_wr_en & (cfg_port == pin_pkg::PORT_AUX) & (cfg_reg == pin_pkg::REG_AUX);

  // ==========================================
  // filter sample clock: every bus clock, or the RC divider in stop
  assign sample_en = stop_mode ? rc_tick_r : 1'b1;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rc_cnt_r <= 7'h00;
      rc_tick_r <= 1'b0;
    end else if (stop_mode && (wk.rc_run || wa.rc_run)) begin
      rc_tick_r <= (rc_cnt_r == 7'(RC_DIV - 1));
      rc_cnt_r <= (rc_cnt_r == 7'(RC_DIV - 1)) ? 7'h00 : rc_cnt_r + 7'h01;
    end else begin
      rc_cnt_r <= 7'h00;
      rc_tick_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) rc_osc_run <= 1'b0;
    else rc_osc_run <= stop_mode & (wk.rc_run | wa.rc_run);
  end

  // ==========================================
  // filters
  edge_wake_filter #(.N(`W_KEY)) u_key (
    .clk(ref_clk),
    .srst(srst),
    .sample_en(sample_en),
    .pin(pin_in[`LSB_KEY +: `W_KEY]),
    .w(wk.filt)
  );

  edge_wake_filter #(.N(`W_AUX)) u_aux (
    .clk(ref_clk),
    .srst(srst),
    .sample_en(sample_en),
    .pin(pin_in[`LSB_AUX +: `W_AUX]),
    .w(wa.filt)
  );

  // ==========================================
  // requests and wake
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      keywake_interrupt_flags <= `W_KEY'(0);
      aux_interrupt_flags <= `W_AUX'(0);
      keywake_irq <= 1'b0;
      aux_irq <= 1'b0;
      stop_wake <= 1'b0;
    end else begin
      keywake_interrupt_flags <= wk.flags;
      aux_interrupt_flags <= wa.flags;
      keywake_irq <= wk.irq;
      aux_irq <= wa.irq;
      stop_wake <= wk.irq | wa.irq;
    end
  end

endmodule : port_integration_pin_logic

// [port_integration_pin_logic_asserts.sv]
// checker for the port integration pin logic top ports
// assumes one ref_clk domain and synchronous srst
`timescale 1ns/1ps
`include "pin_cfg.svh"
module port_integration_pin_logic_asserts #(
  parameter int RC_DIV = 50
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic cfg_wr_en,
  input wire pin_pkg::port_sel_t cfg_port,
  input wire pin_pkg::reg_sel_t cfg_reg,
  input wire logic [7:0] cfg_wdata,
  input wire logic [`PIN_TOTAL-1:0] pin_in,
  input wire logic [`PIN_TOTAL-1:0] periph_en,
  input wire logic [`PIN_TOTAL-1:0] periph_out,
  input wire logic [`PIN_TOTAL-1:0] periph_oe,
  input wire logic [`PIN_TOTAL-1:0] pin_out,
  input wire logic [`PIN_TOTAL-1:0] pin_oe_n,
  input wire logic [`PIN_TOTAL-1:0] pin_rdrv,
  input wire logic [`PIN_TOTAL-1:0] pin_pull_on,
  input wire logic [`PIN_TOTAL-1:0] pin_rd,
  input wire logic [`W_KEY-1:0] keywake_interrupt_enables,
  input wire logic [`W_AUX-1:0] aux_interrupt_enables,
  input wire logic [`W_KEY-1:0] keywake_interrupt_flags,
  input wire logic [`W_AUX-1:0] aux_interrupt_flags,
  input wire logic keywake_irq,
  input wire logic aux_irq,
  input wire logic stop_wake,
  input wire logic rc_osc_run
);
  // ==========================================
  // flag clear writes, one and two edges back
  logic [7:0] clr1_r;
  logic [7:0] clr2_r;
  always_ff @(posedge ref_clk) begin
    clr1_r <= (cfg_wr_en && cfg_port == pin_pkg::PORT_KEY && cfg_reg == pin_pkg::REG_AUX) ? cfg_wdata : 8'h00;
    clr2_r <= clr1_r;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // ==========================================
  // properties
  a_input_read_live: assert property (!$past(srst) |-> pin_rd == $past(pin_in))
    else $error("input read differs from pin level");
  a_reset_port_state: assert property ($fell(srst) |-> pin_oe_n == '1 && pin_rdrv == '0
    && pin_pull_on == 36'h0_0003_ff00 && keywake_interrupt_enables == '0 && aux_interrupt_enables == '0)
    else $error("port state after reset wrong");
  a_irq_on_flag: assert property ((keywake_interrupt_flags & keywake_interrupt_enables) != 8'h00
    |-> ##[0:3] keywake_irq) else $error("keywake request missing");
  a_irq_off_idle: assert property (((keywake_interrupt_flags & keywake_interrupt_enables) == 8'h00)[*4]
    |-> !keywake_irq) else $error("keywake request without flag");
  a_aux_irq_on: assert property ((aux_interrupt_flags & aux_interrupt_enables) != 2'h0 |-> ##[0:3] aux_irq)
    else $error("aux request missing");
  a_flag_w1c: assert property ((($past(keywake_interrupt_flags) & ~keywake_interrupt_flags)
    & ~(clr1_r | clr2_r)) == 8'h00) else $error("flag cleared without write of one");
  a_periph_drive: assert property ((periph_en[8] && periph_oe[8] && $stable(periph_out[8]))[*3]
    |-> !pin_oe_n[8] && pin_out[8] == periph_out[8]) else $error("peripheral not driving pin");
  a_wake_follows: assert property ((keywake_irq || aux_irq) |-> ##[0:2] stop_wake)
    else $error("wake missing");
  a_rc_needs_en: assert property (rc_osc_run |-> |{keywake_interrupt_enables, aux_interrupt_enables,
    $past(keywake_interrupt_enables), $past(aux_interrupt_enables)}) else $error("oscillator runs unarmed");
endmodule : port_integration_pin_logic_asserts

bind port_integration_pin_logic port_integration_pin_logic_asserts #(.RC_DIV(RC_DIV)) checker_i (
  .ref_clk, .srst, .cfg_wr_en, .cfg_port, .cfg_reg, .cfg_wdata, .pin_in, .periph_en, .periph_out,
  .periph_oe, .pin_out, .pin_oe_n, .pin_rdrv, .pin_pull_on, .pin_rd, .keywake_interrupt_enables,
  .aux_interrupt_enables, .keywake_interrupt_flags, .aux_interrupt_flags, .keywake_irq, .aux_irq,
  .stop_wake, .rc_osc_run);

// [port_integration_pin_logic_tb.sv]
// self-checking bench for the port integration pin logic
// assumes pin_partner as the pins and a small stop-mode divider
`timescale 1ns/1ps
`include "pin_cfg.svh"
module port_integration_pin_logic_tb;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic cfg_wr_en = 1'b0;
  logic stop_mode = 1'b0;
  pin_pkg::port_sel_t cfg_port = pin_pkg::PORT_TIM;
  pin_pkg::reg_sel_t cfg_reg = pin_pkg::REG_DATA;
  logic [7:0] cfg_wdata = 8'h00;
  logic [35:0] periph_en = '0, periph_out = '0, periph_oe = '0;
  logic [35:0] ext_en = 36'hf_0ffc_0000, ext_val = 36'h3_0008_0000;
  logic [3:0] pwm_reroute_out = 4'h0;
  logic [35:0] pin_in, pin_out, pin_oe_n, pin_rdrv, pin_pull_on, pin_pull_up, data_rd, pin_rd;
  logic [3:0] module_routing_select;
  logic [7:0] ke, kf;
  logic [1:0] ae, af;
  logic keywake_irq, aux_irq, stop_wake, rc_osc_run;
  int n_errors = 0, num_checks = 0, cyc_cnt = 0;
  port_integration_pin_logic #(.RC_DIV(2)) port_integration_pin_logic_i (.ref_clk, .srst, .cfg_wr_en,
    .cfg_port, .cfg_reg, .cfg_wdata, .pin_in, .periph_en, .periph_out, .periph_oe, .pwm_reroute_out,
    .stop_mode, .pin_out, .pin_oe_n, .pin_rdrv, .pin_pull_on, .pin_pull_up, .data_rd, .pin_rd,
    .module_routing_select, .keywake_interrupt_enables(ke), .aux_interrupt_enables(ae),
    .keywake_interrupt_flags(kf), .aux_interrupt_flags(af), .keywake_irq, .aux_irq, .stop_wake, .rc_osc_run);
  pin_partner pin_partner_i (.clk(ref_clk), .pin_out, .pin_oe_n, .pull_on(pin_pull_on),
    .pull_up(pin_pull_up), .ext_en, .ext_val, .pin_lvl(pin_in));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  // ==========================================
  // shared tasks
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  always @(posedge ref_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 5000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic wr(input pin_pkg::port_sel_t p, input pin_pkg::reg_sel_t r, input logic [7:0] d);
    @(posedge ref_clk);
    cfg_wr_en <= 1'b1;
    cfg_port <= p;
    cfg_reg <= r;
    cfg_wdata <= d;
    @(posedge ref_clk);
    cfg_wr_en <= 1'b0;
  endtask : wr
  task automatic pulse(input int b, input int n, input logic lvl);
    @(posedge ref_clk);
    ext_val[b] <= lvl;
    repeat (n) @(posedge ref_clk);
    ext_val[b] <= ~lvl;
  endtask : pulse
  // ==========================================
  // scenarios
  task automatic t_reset();
    @(posedge ref_clk);
    srst <= 1'b1;
    stop_mode <= 1'b0;
    periph_en <= '0;
    periph_oe <= '0;
    periph_out <= '0;
    pwm_reroute_out <= 4'h0;
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    cyc(2);
    chk(pin_oe_n, 36'hf_ffff_ffff);
    chk(pin_out, '0);
    chk(pin_pull_on, 36'h0_0003_ff00);
    chk(pin_pull_up, 36'h0_0003_ff00);
    chk(pin_rdrv, '0);
    chk({kf, ke, af, ae}, '0);
  endtask : t_reset
  task automatic t_gpio();
    wr(pin_pkg::PORT_ANA, pin_pkg::REG_DATA, 8'ha5);
    cyc(4);
    chk(pin_oe_n[35:28], 8'hff);
    chk(data_rd[35:32], 4'h3);
    chk(pin_rd[35:32], 4'h3);
    wr(pin_pkg::PORT_ANA, pin_pkg::REG_DIR, 8'h0f);
    cyc(4);
    chk(data_rd[35:28], 8'h35);
    chk(pin_oe_n[31:28], 4'h0);
    chk(pin_out[31:28], 4'h5);
    chk(pin_rd[31:28], 4'h5);
    wr(pin_pkg::PORT_ANA, pin_pkg::REG_RDRV, 8'hff);
    wr(pin_pkg::PORT_ANA, pin_pkg::REG_PULLEN, 8'hff);
    wr(pin_pkg::PORT_ANA, pin_pkg::REG_PULLSEL, 8'hf0);
    cyc(4);
    chk(pin_rdrv[35:28], 8'h0f);
    chk(pin_pull_on[35:28], 8'hf0);
    chk(pin_pull_up[35:32], 4'hf);
    wr(pin_pkg::PORT_ANA, pin_pkg::REG_WOR, 8'h0f);
    cyc(4);
    chk(pin_oe_n[31:28], 4'h5);
    chk(pin_pull_on[31:28] & ~pin_pull_up[31:28], 4'h0);
  endtask : t_gpio
  task automatic t_periph();
    wr(pin_pkg::PORT_SER, pin_pkg::REG_DIR, 8'h03);
    @(posedge ref_clk);
    periph_en[9:8] <= 2'h3;
    periph_oe[9:8] <= 2'h1;
    periph_out[8] <= 1'b1;
    cyc(4);
    chk(pin_oe_n[9:8], 2'h2);
    chk(pin_out[8], 1'b1);
  endtask : t_periph
  task automatic t_route();
    wr(pin_pkg::PORT_TIM, pin_pkg::REG_AUX, 8'h01);
    @(posedge ref_clk);
    pwm_reroute_out <= 4'h1;
    cyc(4);
    chk(module_routing_select, 4'h1);
    chk(pin_oe_n[1:0], 2'h2);
    chk(pin_out[0], 1'b1);
  endtask : t_route
  task automatic t_filter();
    wr(pin_pkg::PORT_KEY, pin_pkg::REG_PULLSEL, 8'h01);
    wr(pin_pkg::PORT_KEY, pin_pkg::REG_IE, 8'h03);
    wr(pin_pkg::PORT_AUX, pin_pkg::REG_PULLSEL, 8'h01);
    wr(pin_pkg::PORT_AUX, pin_pkg::REG_IE, 8'h01);
    cyc(8);
    chk({ke, ae}, 10'h00d);
    pulse(18, 3, 1'b1);
    cyc(10);
    chk({kf, keywake_irq}, 9'h000);
    pulse(18, 4, 1'b1);
    cyc(10);
    chk(kf, 8'h01);
    chk({keywake_irq, stop_wake}, 2'h3);
    wr(pin_pkg::PORT_KEY, pin_pkg::REG_AUX, 8'h00);
    cyc(4);
    chk(kf, 8'h01);
    wr(pin_pkg::PORT_KEY, pin_pkg::REG_AUX, 8'h01);
    cyc(4);
    chk({kf, keywake_irq}, 9'h000);
    pulse(19, 5, 1'b0);
    cyc(10);
    chk(kf, 8'h02);
    pulse(26, 4, 1'b1);
    cyc(10);
    chk({af, aux_irq}, 3'h3);
    wr(pin_pkg::PORT_KEY, pin_pkg::REG_AUX, 8'hff);
    wr(pin_pkg::PORT_AUX, pin_pkg::REG_AUX, 8'h03);
  endtask : t_filter
  task automatic t_stop();
    wr(pin_pkg::PORT_KEY, pin_pkg::REG_IE, 8'h04);
    wr(pin_pkg::PORT_AUX, pin_pkg::REG_IE, 8'h00);
    wr(pin_pkg::PORT_KEY, pin_pkg::REG_PULLSEL, 8'h05);
    cyc(6);
    @(posedge ref_clk);
    stop_mode <= 1'b1;
    cyc(4);
    chk(rc_osc_run, 1'b1);
    pulse(20, 2, 1'b1);
    cyc(30);
    chk(kf, 8'h00);
    pulse(20, 16, 1'b1);
    cyc(40);
    chk(kf, 8'h04);
    chk({stop_wake, rc_osc_run}, 2'h2);
  endtask : t_stop
  initial begin
    t_reset();
    t_gpio();
    t_periph();
    t_route();
    t_filter();
    t_stop();
    t_reset();
    summarize();
  end
endmodule : port_integration_pin_logic_tb

// [wake_if.sv]
// control and status between the top and an edge wake filter
// assumes one clock domain
`timescale 1ns/1ps
interface wake_if #(parameter int N = 8);
  logic [N-1:0] enable;
  logic [N-1:0] polarity;
  logic [N-1:0] clr_mask;
  logic clr_stb;
  logic [N-1:0] flags;
  logic irq;
  logic rc_run;
  modport ctrl(output enable, output polarity, output clr_mask, output clr_stb,
               input flags, input irq, input rc_run);
  modport filt(input enable, input polarity, input clr_mask, input clr_stb,
               output flags, output irq, output rc_run);
endinterface : wake_if
